// ===== core/cbse_edge_detect.sv
`timescale 1ns/1ns
// =========================================================================
// change detector for one status field, compared with the last cycle
module cbse_edge_detect #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] level,
  input  wire logic         rise_only,
  output logic              changed
);
  logic [W-1:0] last;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      last <= '0;
    end else begin
      last <= level;
    end
  end

  // rise_only applies to single-bit fields only; bit 0 is the checked bit
  always_comb begin
    if (rise_only) begin
      changed = level[0] & ~last[0];
    end else begin
      changed = |(level ^ last);
    end
  end
endmodule : cbse_edge_detect

// ===== core/cbse_pkg.sv
package cbse_pkg;

  // =========================================================================
  // register offsets within the socket bank
  localparam logic [5:0] OFF_CHANGE_FLAGS  = 6'h00;
  localparam logic [5:0] OFF_INT_MASK      = 6'h04;
  localparam logic [5:0] OFF_CURRENT_STATE = 6'h08;
  localparam logic [5:0] OFF_EVENT_FORCE   = 6'h0c;
  localparam logic [5:0] OFF_CONTROL       = 6'h10;
  localparam logic [5:0] OFF_RSVD_LO       = 6'h14;
  localparam logic [5:0] OFF_RSVD_HI       = 6'h1c;
  localparam logic [5:0] OFF_POWER_MGMT    = 6'h20;

  // =========================================================================
  // event field positions
  localparam int EVT_STATUS     = 0;
  localparam int EVT_DETECT_ONE = 1;
  localparam int EVT_DETECT_TWO = 2;
  localparam int EVT_POWER      = 3;
  localparam int EVT_W          = 4;

  // =========================================================================
  // reset values
  localparam logic [3:0]  FLAGS_RESET   = 4'h0;
  localparam logic [3:0]  MASK_RESET    = 4'h0;
  localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;
  localparam logic [31:0] POWER_RESET   = 32'h0000_0000;

  // =========================================================================
  // card type on the socket
  typedef enum logic [0:0] {
    CBSE_CARD_CARDBUS = 1'b0,
    CBSE_CARD_16BIT   = 1'b1
  } cbse_card_t;

endpackage : cbse_pkg

// ===== core/cbse_socket_regs.sv
`timescale 1ns/1ns
module cbse_socket_regs
  import cbse_pkg::*;
#(
  parameter int AW = 6
) (
  input  wire logic         clock,
  input  wire logic         rst_n,
  input  wire logic         global_reset_n,
  input  wire logic         pci_bus_reset_n,
  input  wire logic         bank_select,
  input  wire logic [AW-1:0] address,
  input  wire logic         write_strobe,
  input  wire logic         read_strobe,
  input  wire logic [31:0]  write_data,
  output logic [31:0]       read_data,
  input  wire logic         card_detect_line_one,
  input  wire logic         card_detect_line_two,
  input  wire logic         power_cycle_state,
  input  wire logic         card_status_change_signal,
  input  wire cbse_pkg::cbse_card_t card_type,
  input  wire logic         card_reset_active,
  output logic              status_change_interrupt,
  output logic [31:0]       socket_control,
  output logic [31:0]       socket_power_management
);
  import cbse_pkg::*;

  // =========================================================================
  // storage
  logic [EVT_W-1:0] socket_change_flags;
  logic [EVT_W-1:0] socket_interrupt_mask;
  logic [EVT_W-1:0] event_set;
  logic [EVT_W-1:0] clear_bits;
  logic [EVT_W-1:0] force_bits;
  logic [EVT_W-1:0] reentry_bits;
  logic             card_reset_last;
  logic             wake_enable;
  logic [31:0]      next_read_data;
  logic [31:0]      socket_current_state;
  logic             detect_one_state;
  logic             detect_two_state;
  logic             card_status_state;
  logic             pwr_changed;
  logic             cd1_changed;
  logic             cd2_changed;
  logic             sts_changed;
  logic             wr;
  logic             pci_clear;

  // card detect lines are active low at the socket
  assign detect_one_state  = ~card_detect_line_one;
  assign detect_two_state  = ~card_detect_line_two;
  assign card_status_state = card_status_change_signal;

  // wake enable is held in the power management register, bit 8
  assign wake_enable = socket_power_management[8];

  assign wr = bank_select & write_strobe;

  function automatic logic hit(input logic [AW-1:0] a, input logic [5:0] off);
    hit = (a[5:2] == off[5:2]);
  endfunction : hit

  // =========================================================================
  // change detection
  cbse_edge_detect #(.W(1)) u_pwr (
    .clock     (clock),
    .rst_n     (rst_n),
    .level     (power_cycle_state),
    .rise_only (1'b0),
    .changed   (pwr_changed)
  );

  cbse_edge_detect #(.W(1)) u_cd1 (
    .clock     (clock),
    .rst_n     (rst_n),
    .level     (detect_one_state),
    .rise_only (1'b0),
    .changed   (cd1_changed)
  );

  cbse_edge_detect #(.W(1)) u_cd2 (
    .clock     (clock),
    .rst_n     (rst_n),
    .level     (detect_two_state),
    .rise_only (1'b0),
    .changed   (cd2_changed)
  );

  cbse_edge_detect #(.W(1)) u_sts (
    .clock     (clock),
    .rst_n     (rst_n),
    .level     (card_status_state),
    .rise_only (card_type == CBSE_CARD_CARDBUS),
    .changed   (sts_changed)
  );

  // =========================================================================
  // leaving card reset: re-raise status and detect events whose cause still stands
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      card_reset_last <= 1'b0;
    end else begin
      card_reset_last <= card_reset_active;
    end
  end

  always_comb begin
    reentry_bits = '0;
    if (card_reset_last && !card_reset_active) begin
      reentry_bits[EVT_STATUS]     = card_status_state;
      reentry_bits[EVT_DETECT_ONE] = detect_one_state;
      reentry_bits[EVT_DETECT_TWO] = detect_two_state;
    end
  end

  // =========================================================================
  // event flags
  always_comb begin
    force_bits = '0;
    clear_bits = '0;
    if (wr && hit(address, OFF_EVENT_FORCE)) begin
      force_bits = write_data[EVT_W-1:0];
    end
    if (wr && hit(address, OFF_CHANGE_FLAGS)) begin
      clear_bits = write_data[EVT_W-1:0];
    end
    event_set = force_bits | reentry_bits;
    event_set[EVT_POWER]      = event_set[EVT_POWER] | pwr_changed;
    event_set[EVT_DETECT_ONE] = event_set[EVT_DETECT_ONE] | cd1_changed;
    event_set[EVT_DETECT_TWO] = event_set[EVT_DETECT_TWO] | cd2_changed;
    event_set[EVT_STATUS]     = event_set[EVT_STATUS] | sts_changed;
  end

  // pci reset is ignored for wake context while wake signalling is enabled
  assign pci_clear = !pci_bus_reset_n && !wake_enable;

  always_ff @(posedge clock) begin
    if (!rst_n || !global_reset_n || pci_clear) begin
      socket_change_flags <= FLAGS_RESET;
    end else begin
      // set wins over clear; zero in write data leaves the flag alone
      socket_change_flags <= (socket_change_flags & ~clear_bits) | event_set;
    end
  end

  // =========================================================================
  // mask, control, power management
  always_ff @(posedge clock) begin
    if (!rst_n || !global_reset_n || pci_clear) begin
      socket_interrupt_mask <= MASK_RESET;
    end else if (wr && hit(address, OFF_INT_MASK)) begin
      socket_interrupt_mask <= write_data[EVT_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || !global_reset_n || !pci_bus_reset_n) begin
      socket_control <= CONTROL_RESET;
    end else if (wr && hit(address, OFF_CONTROL)) begin
      socket_control <= write_data;
    end
  end

  // held through pci reset; only rst_n or global reset returns it to default
  always_ff @(posedge clock) begin
    if (!rst_n || !global_reset_n) begin
      socket_power_management <= POWER_RESET;
    end else if (wr && hit(address, OFF_POWER_MGMT)) begin
      socket_power_management <= write_data;
    end
  end

  // =========================================================================
  // interrupt: any flag that is set and unmasked
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      status_change_interrupt <= 1'b0;
    end else begin
      status_change_interrupt <= |(socket_change_flags & socket_interrupt_mask);
    end
  end

  // =========================================================================
  // read path
  always_comb begin
    socket_current_state = '0;
    socket_current_state[EVT_POWER]      = power_cycle_state;
    socket_current_state[EVT_DETECT_TWO] = detect_two_state;
    socket_current_state[EVT_DETECT_ONE] = detect_one_state;
    socket_current_state[EVT_STATUS]     = card_status_state;
  end

  always_comb begin
    next_read_data = 32'h0000_0000;
    if (hit(address, OFF_CHANGE_FLAGS)) begin
      next_read_data[EVT_W-1:0] = socket_change_flags;
    end else if (hit(address, OFF_INT_MASK)) begin
      next_read_data[EVT_W-1:0] = socket_interrupt_mask;
    end else if (hit(address, OFF_CURRENT_STATE)) begin
      next_read_data = socket_current_state;
    end else if (hit(address, OFF_CONTROL)) begin
      next_read_data = socket_control;
    end else if (hit(address, OFF_POWER_MGMT)) begin
      next_read_data = socket_power_management;
    end
    // force register is write-only; reserved 14h..1Ch fall through as zero
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      read_data <= 32'h0000_0000;
    end else if (bank_select && read_strobe) begin
      read_data <= next_read_data;
    end
  end
endmodule : cbse_socket_regs

// ===== testbench/cbse_card_model.sv
`timescale 1ns/1ns
// ====================
// card side: pin levels follow the requested card state
module cbse_card_model
  import cbse_pkg::*;
(
  input  wire logic [3:0]   state_req,
  input  wire logic         type_req,
  input  wire logic         hold_req,
  output logic              card_detect_line_one,
  output logic              card_detect_line_two,
  output logic              power_cycle_state,
  output logic              card_status_change_signal,
  output cbse_pkg::cbse_card_t card_type,
  output logic              card_reset_active
);
  // detect lines are active low, so an inserted card pulls them down
  assign card_detect_line_one = ~state_req[1];
  assign card_detect_line_two = ~state_req[2];
  assign power_cycle_state = state_req[3];
  assign card_status_change_signal = state_req[0];
  assign card_type = cbse_card_t'(type_req);
  assign card_reset_active = hold_req;
endmodule : cbse_card_model

// ===== testbench/cbse_socket_monitor.sv
`timescale 1ns/1ns
// ====================
// port-level checker for the socket bank
module cbse_socket_monitor
  import cbse_pkg::*;
#(
  parameter int AW = 6
) (
  input wire logic          clock,
  input wire logic          rst_n,
  input wire logic          global_reset_n,
  input wire logic          pci_bus_reset_n,
  input wire logic          bank_select,
  input wire logic [AW-1:0] address,
  input wire logic          write_strobe,
  input wire logic          read_strobe,
  input wire logic [31:0]   write_data,
  input wire logic [31:0]   read_data,
  input wire logic          status_change_interrupt,
  input wire logic [31:0]   socket_control,
  input wire logic [31:0]   socket_power_management
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire wr = bank_select && write_strobe;
  wire rd = bank_select && read_strobe;
  wire up = global_reset_n && pci_bus_reset_n;
  sequence mask_all;
    wr && up && address[5:2] == 4'h1 && write_data[3:0] == 4'hf;
  endsequence
  sequence force_all;
    wr && up && address[5:2] == 4'h3 && write_data[3:0] == 4'hf;
  endsequence
  sequence mask_none;
    wr && up && address[5:2] == 4'h1 && write_data[3:0] == 4'h0 ##1 !(wr && address[5:2] == 4'h1);
  endsequence
  force_raise_a: assert property (mask_all ##1 force_all |=> ##1 status_change_interrupt)
    else $error("forced unmasked flag gave no interrupt");
  mask_quiet_a: assert property (mask_none |=> !status_change_interrupt)
    else $error("interrupt with all events masked");
  control_write_a: assert property (wr && up && address[5:2] == 4'h4 |=> socket_control == $past(write_data))
    else $error("control write not taken");
  pm_write_a: assert property (wr && up && address[5:2] == 4'h8 |=> socket_power_management == $past(write_data))
    else $error("power management write not taken");
  pm_survive_a: assert property (global_reset_n && !pci_bus_reset_n && !wr |=> $stable(socket_power_management))
    else $error("power management lost on pci reset");
  global_clear_a: assert property (!global_reset_n |=> socket_power_management == 32'h0 && socket_control == 32'h0)
    else $error("global reset left registers set");
  reserved_read_a: assert property (rd && address[5:2] inside {4'h5, 4'h6, 4'h7} |=> read_data == 32'h0)
    else $error("reserved offset read non-zero");
  event_upper_a: assert property (rd && address[5:2] == 4'h0 |=> read_data[31:4] == 28'h0)
    else $error("event register upper bits non-zero");
endmodule : cbse_socket_monitor

bind cbse_socket_regs cbse_socket_monitor #(.AW(AW)) i_cbse_socket_monitor (
  .clock(clock), .rst_n(rst_n), .global_reset_n(global_reset_n),
  .pci_bus_reset_n(pci_bus_reset_n), .bank_select(bank_select), .address(address),
  .write_strobe(write_strobe), .read_strobe(read_strobe), .write_data(write_data),
  .read_data(read_data), .status_change_interrupt(status_change_interrupt),
  .socket_control(socket_control), .socket_power_management(socket_power_management));

// ===== testbench/tb.sv
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin mismatches++; $display("BAD %0t got %h want %h", $time, (a), (e)); end end
module tb;
  import cbse_pkg::*;
  logic        clock, rst_n, global_reset_n, pci_bus_reset_n;
  logic        bank_select, write_strobe, read_strobe, status_change_interrupt;
  logic [5:0]  address;
  logic [31:0] write_data, read_data, socket_control, socket_power_management;
  logic        cd1, cd2, pwr, csc, crst, hold, ty;
  logic [3:0]  req;
  cbse_card_t  ctype;
  int          mismatches = 0;
  int          check_count = 0;
  cbse_socket_regs i_cbse_socket_regs (.clock, .rst_n, .global_reset_n, .pci_bus_reset_n,
    .bank_select, .address, .write_strobe, .read_strobe, .write_data, .read_data,
    .card_detect_line_one(cd1), .card_detect_line_two(cd2), .power_cycle_state(pwr),
    .card_status_change_signal(csc), .card_type(ctype), .card_reset_active(crst),
    .status_change_interrupt, .socket_control, .socket_power_management);
  cbse_card_model i_cbse_card_model (.state_req(req), .type_req(ty), .hold_req(hold),
    .card_detect_line_one(cd1), .card_detect_line_two(cd2), .power_cycle_state(pwr),
    .card_status_change_signal(csc), .card_type(ctype), .card_reset_active(crst));
  // ====================
  // access tasks; strobes stay up after wr so writes can run back to back
  task automatic idle;
    @(negedge clock);
    {bank_select, write_strobe, read_strobe} = 3'b000;
  endtask : idle
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(negedge clock);
    {bank_select, write_strobe, read_strobe} = 3'b110;
    address = a;
    write_data = d;
  endtask : wr
  task automatic rc(input logic [5:0] a, input logic [31:0] e);
    @(negedge clock);
    {bank_select, write_strobe, read_strobe} = 3'b101;
    address = a;
    idle();
    `CHK(read_data, e)
  endtask : rc
  task automatic settle;
    idle();
    repeat (3) @(negedge clock);
  endtask : settle
  task automatic pulse(input logic g);
    idle();
    global_reset_n = !g;
    pci_bus_reset_n = g;
    @(negedge clock);
    {global_reset_n, pci_bus_reset_n} = 2'b11;
  endtask : pulse
  task automatic wrap_up;
    if (mismatches == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  // ====================
  // stimulus
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    #20000;
    mismatches++;
    wrap_up();
  end
  initial begin
    {rst_n, bank_select, write_strobe, read_strobe, req, hold, ty} = '0;
    {global_reset_n, pci_bus_reset_n} = 2'b11;
    address = 6'h00;
    write_data = 32'h0;
    repeat (12) @(negedge clock);
    rst_n = 1'b1;
    for (int i = 0; i < 9; i++) rc(6'(i * 4), 32'h0);
    wr(6'h08, '1);
    rc(6'h08, 32'h0);
    wr(6'h0c, '1);
    rc(6'h00, 32'hf);
    wr(6'h00, 32'h5);
    rc(6'h00, 32'ha);
    wr(6'h00, 32'h0);
    rc(6'h00, 32'ha);
    wr(6'h04, '1);
    wr(6'h0c, '1);
    settle();
    `CHK(status_change_interrupt, 1'b1)
    rc(6'h04, 32'hf);
    wr(6'h04, 32'h0);
    settle();
    `CHK(status_change_interrupt, 1'b0)
    rc(6'h00, 32'hf);
    wr(6'h00, '1);
    rc(6'h00, 32'h0);
    for (int i = 1; i < 4; i++) begin
      req[i] = 1'b1;
      settle();
      rc(6'h00, 32'h1 << i);
      rc(6'h08, 32'(req));
      wr(6'h00, '1);
      rc(6'h00, 32'h0);
      req[i] = 1'b0;
      settle();
      rc(6'h00, 32'h1 << i);
      wr(6'h00, '1);
    end
    // clear and reset release land on one edge: only re-entry can leave flags
    req = 4'h6;
    hold = 1'b1;
    settle();
    wr(6'h00, '1);
    hold = 1'b0;
    settle();
    rc(6'h00, 32'h6);
    wr(6'h00, '1);
    req[0] = 1'b1;
    settle();
    rc(6'h00, 32'h1);
    wr(6'h00, '1);
    req[0] = 1'b0;
    settle();
    rc(6'h00, 32'h0);
    ty = 1'b1;
    req[0] = 1'b1;
    settle();
    wr(6'h00, '1);
    req[0] = 1'b0;
    settle();
    rc(6'h00, 32'h1);
    req = 4'h0;
    settle();
    wr(6'h00, '1);
    wr(6'h0c, '1);
    pulse(1'b0);
    rc(6'h00, 32'h0);
    wr(6'h10, 32'h5a);
    wr(6'h20, 32'h100);
    wr(6'h0c, '1);
    pulse(1'b0);
    rc(6'h00, 32'hf);
    rc(6'h20, 32'h100);
    rc(6'h10, 32'h0);
    pulse(1'b1);
    rc(6'h00, 32'h0);
    rc(6'h20, 32'h0);
    wrap_up();
  end
endmodule : tb
